// ---- core/dbt_cfg.svh ----
// Offsets, field positions, reset values and counts of the debug/trace unit.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one register per word.
`ifndef DBT_CFG_SVH
`define DBT_CFG_SVH
`define DBT_OFF_BDC_CS 8'h00
`define DBT_OFF_BDC_BKPT 8'h04
`define DBT_OFF_CMPA 8'h08
`define DBT_OFF_CMPB 8'h0c
`define DBT_OFF_TCTRL 8'h10
`define DBT_OFF_TSTAT 8'h14
`define DBT_OFF_FIFOH 8'h18
`define DBT_OFF_FIFOL 8'h1c
`define DBT_CS_CTRL_BREAKPOINT_ENABLE 0
`define DBT_CS_FTS 1
`define DBT_TC_ARM 0
`define DBT_TC_BRKEN 1
`define DBT_TC_TAG 2
`define DBT_TC_TRGSEL 3
`define DBT_TC_BEGIN 4
`define DBT_TC_CMP_A_DIR_QUAL_ENABLE 5
`define DBT_TC_RWA 6
`define DBT_TC_RWBEN 7
`define DBT_TC_RWB 8
`define DBT_TC_MODE_LSB 12
`define DBT_TS_ARMF 0
`define DBT_TS_AF 1
`define DBT_TS_BF 2
`define DBT_TS_CNT_LSB 8
`define DBT_FIFO_DEPTH 4'h8
`define DBT_SKIP_CYCLES 2'h2
`define DBT_RST_WORD 16'h0000
`endif

// ---- core/dbt_pkg.sv ----
// Types shared by the debug/trace unit files.
// Assumes the constants of dbt_cfg.svh for field widths.
package dbt_pkg;
   typedef enum logic [3:0] {
      MODE_A_ONLY = 4'h0, MODE_A_OR_B = 4'h1, MODE_A_THEN_B = 4'h2,
      MODE_EVENT_B = 4'h3, MODE_A_THEN_EVENT_B = 4'h4, MODE_INSIDE = 4'h5,
      MODE_OUTSIDE = 4'h6, MODE_A_AND_B_DATA = 4'h7, MODE_A_AND_NOT_B_DATA = 4'h8
   } dbt_mode_t;
   typedef enum logic [2:0] {
      COF_NONE = 3'h0, COF_COND_TAKEN = 3'h1, COF_ALWAYS = 3'h2, COF_NEVER = 3'h3,
      COF_INDIRECT = 3'h4, COF_INTERRUPT = 3'h5, COF_RETURN = 3'h6, COF_DIRECT = 3'h7
   } dbt_cof_kind_t;
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic rw;
      logic [7:0] rdData;
      logic [7:0] wrData;
      logic bdcAccess;
      logic opFetch;
      logic opExec;
      logic [15:0] execAddr;
      logic instrBoundary;
   } dbt_cpu_t;
   typedef struct packed {
      logic valid;
      dbt_cof_kind_t kind;
      logic [15:0] src;
      logic [15:0] dst;
   } dbt_cof_t;
   typedef struct packed {
      logic ctrl_breakpoint_enable, force_tag_select;
      logic [15:0] bkptMatch, cmpA, cmpB;
      dbt_mode_t mode;
      logic brkEn, tagSel, trgSel, beginSel, cmp_a_dir_qual_enable, cmp_a_dir_expected, rwbEn, rwb;
      logic armed, af, bf, seenA, tracing;
      logic [1:0] skip;
      logic [3:0] cnt;
      logic [2:0] wrPtr, rdPtr;
      logic [15:0] lastFetch;
      logic forcePend, tagOut;
      logic wrPend, wrDbg;
      logic [7:0] wrAddr;
      logic [31:0] hrdata;
   } dbt_state_t;
endpackage

// ---- core/dbt_fifo_mem.sv ----
// Small trace memory: one write port, one read port with registered data.
// Assumes the owner keeps pointers in range; read data lag the address by one edge.
`timescale 1ns/1ps
module dbt_fifo_mem #(
   parameter int W = 16,
   parameter int D = 8,
   parameter int AW = 3
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [W-1:0] wrData,
   // Read port
   input wire logic [AW-1:0] rdAddr,
   output logic [W-1:0] rdData
);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [W-1:0] rd;
   } dbt_mem_st_t;
   dbt_mem_st_t r, n;
   always_comb begin
      n = r;
      n.rd = r.mem[rdAddr];
      if (wrEn) begin
         n.mem[wrAddr] = wrData;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign rdData = r.rd;
endmodule // dbt_fifo_mem

// ---- core/dbt_top.sv ----
// Debug breakpoint and trace unit: controller breakpoint, comparators A/B, trace FIFO.
// Assumes CPU strobes on ref_clk and a non-pipelined AHB-Lite master.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_top
   import dbt_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // High while the transfer comes from the serial debug port
   input wire logic dbgPortAccess,
   // CPU buses and flow events
   input wire dbt_cpu_t cpu,
   input wire dbt_cof_t cof,
   // Requests to the CPU
   output logic bgndForce,
   output logic opTag
);
   dbt_state_t r, n;
   logic acc, lowRead, stVal, evMode, fullMode, cofHit;
   logic aVal, rwOkA, rwOkB, hitA, hitB, eqBd, trig, tagTrig, ctrlHit;
   logic [15:0] aAddr, stData, cofAddr, fifoWord;
   logic [7:0] dataB;

   function automatic logic [2:0] ptrInc(input logic [2:0] p);
      ptrInc = 3'(p + 3'h1);
   endfunction

   assign acc = hsel && hready && htrans[1];
   assign lowRead = acc && !hwrite && haddr[7:0] == `DBT_OFF_FIFOL;

   always_comb begin
      aAddr = r.trgSel ? cpu.execAddr : cpu.addr;
      aVal = (r.trgSel ? cpu.opExec : cpu.valid) && !cpu.bdcAccess;
      rwOkA = r.trgSel || !r.cmp_a_dir_qual_enable || cpu.rw == r.cmp_a_dir_expected;
      rwOkB = r.trgSel || !r.rwbEn || cpu.rw == r.rwb;
      dataB = (r.cmp_a_dir_qual_enable && !r.cmp_a_dir_expected) ? cpu.wrData : cpu.rdData;
      hitA = aVal && aAddr == r.cmpA && rwOkA;
      hitB = aVal && aAddr == r.cmpB && rwOkB;
      eqBd = dataB == r.cmpB[7:0];
      evMode = r.mode == MODE_EVENT_B || r.mode == MODE_A_THEN_EVENT_B;
      fullMode = r.mode == MODE_A_AND_B_DATA || r.mode == MODE_A_AND_NOT_B_DATA;
      case (r.mode)
         MODE_A_ONLY: trig = hitA;
         MODE_A_OR_B: trig = hitA || hitB;
         MODE_A_THEN_B: trig = hitB && r.seenA;
         MODE_EVENT_B: trig = hitB;
         MODE_A_THEN_EVENT_B: trig = hitB && r.seenA;
         MODE_INSIDE: trig = aVal && rwOkA && aAddr >= r.cmpA && aAddr <= r.cmpB;
         MODE_OUTSIDE: trig = aVal && rwOkA && (aAddr < r.cmpA || aAddr > r.cmpB);
         MODE_A_AND_B_DATA: trig = hitA && eqBd;
         MODE_A_AND_NOT_B_DATA: trig = hitA && !eqBd;
         default: trig = 1'b0;
      endcase
      tagTrig = fullMode ? hitA : trig;
   end

   always_comb begin
      cofHit = 1'b0;
      cofAddr = cof.dst;
      if (cof.valid) begin
         case (cof.kind)
            COF_COND_TAKEN: begin
               cofHit = 1'b1;
               cofAddr = cof.src;
            end
            COF_INDIRECT, COF_INTERRUPT, COF_RETURN: cofHit = 1'b1;
            default: cofHit = 1'b0;
         endcase
      end
   end

   assign ctrlHit = r.ctrl_breakpoint_enable && cpu.valid && cpu.addr == r.bkptMatch;

   always_comb begin
      n = r;
      stVal = 1'b0;
      stData = `DBT_RST_WORD;
      n.tagOut = 1'b0;
      // Address phase: capture write target, read data straight into hrdata
      n.wrPend = acc && hwrite;
      n.wrAddr = haddr[7:0];
      n.wrDbg = dbgPortAccess;
      if (acc && !hwrite) begin
         n.hrdata = 32'h0000_0000;
         if (haddr[7:0] == `DBT_OFF_BDC_CS) begin
            if (dbgPortAccess) begin
               n.hrdata[`DBT_CS_CTRL_BREAKPOINT_ENABLE] = r.ctrl_breakpoint_enable;
               n.hrdata[`DBT_CS_FTS] = r.force_tag_select;
            end
         end else if (haddr[7:0] == `DBT_OFF_BDC_BKPT) begin
            if (dbgPortAccess) begin
               n.hrdata[15:0] = r.bkptMatch;
            end
         end else if (haddr[7:0] == `DBT_OFF_CMPA) begin
            n.hrdata[15:0] = r.cmpA;
         end else if (haddr[7:0] == `DBT_OFF_CMPB) begin
            n.hrdata[15:0] = r.cmpB;
         end else if (haddr[7:0] == `DBT_OFF_TCTRL) begin
            n.hrdata[`DBT_TC_ARM] = r.armed;
            n.hrdata[`DBT_TC_BRKEN] = r.brkEn;
            n.hrdata[`DBT_TC_TAG] = r.tagSel;
            n.hrdata[`DBT_TC_TRGSEL] = r.trgSel;
            n.hrdata[`DBT_TC_BEGIN] = r.beginSel;
            n.hrdata[`DBT_TC_CMP_A_DIR_QUAL_ENABLE] = r.cmp_a_dir_qual_enable;
            n.hrdata[`DBT_TC_RWA] = r.cmp_a_dir_expected;
            n.hrdata[`DBT_TC_RWBEN] = r.rwbEn;
            n.hrdata[`DBT_TC_RWB] = r.rwb;
            n.hrdata[`DBT_TC_MODE_LSB+:4] = r.mode;
         end else if (haddr[7:0] == `DBT_OFF_TSTAT) begin
            n.hrdata[`DBT_TS_ARMF] = r.armed;
            n.hrdata[`DBT_TS_AF] = r.af;
            n.hrdata[`DBT_TS_BF] = r.bf;
            n.hrdata[`DBT_TS_CNT_LSB+:4] = r.cnt;
         end else if (haddr[7:0] == `DBT_OFF_FIFOH) begin
            n.hrdata[7:0] = fifoWord[15:8];
         end else if (haddr[7:0] == `DBT_OFF_FIFOL) begin
            n.hrdata[7:0] = fifoWord[7:0];
         end
      end
      // Data phase of a write
      if (r.wrPend) begin
         if (r.wrAddr == `DBT_OFF_BDC_CS) begin
            if (r.wrDbg) begin
               n.ctrl_breakpoint_enable = hwdata[`DBT_CS_CTRL_BREAKPOINT_ENABLE];
               n.force_tag_select = hwdata[`DBT_CS_FTS];
            end
         end else if (r.wrAddr == `DBT_OFF_BDC_BKPT) begin
            if (r.wrDbg) begin
               n.bkptMatch = hwdata[15:0];
            end
         end else if (r.wrAddr == `DBT_OFF_CMPA) begin
            n.cmpA = hwdata[15:0];
         end else if (r.wrAddr == `DBT_OFF_CMPB) begin
            n.cmpB = hwdata[15:0];
         end else if (r.wrAddr == `DBT_OFF_TCTRL) begin
            n.brkEn = hwdata[`DBT_TC_BRKEN];
            n.tagSel = hwdata[`DBT_TC_TAG];
            n.trgSel = hwdata[`DBT_TC_TRGSEL];
            n.beginSel = hwdata[`DBT_TC_BEGIN];
            n.cmp_a_dir_qual_enable = hwdata[`DBT_TC_CMP_A_DIR_QUAL_ENABLE];
            n.cmp_a_dir_expected = hwdata[`DBT_TC_RWA];
            n.rwbEn = hwdata[`DBT_TC_RWBEN];
            n.rwb = hwdata[`DBT_TC_RWB];
            n.mode = dbt_mode_t'(hwdata[`DBT_TC_MODE_LSB+:4]);
            if (hwdata[`DBT_TC_ARM]) begin
               n.armed = 1'b1;
               n.af = 1'b0;
               n.bf = 1'b0;
               n.cnt = 4'h0;
               n.seenA = 1'b0;
               n.tracing = 1'b0;
               n.skip = 2'h0;
               n.wrPtr = 3'h0;
               n.rdPtr = 3'h0;
            end else if (r.armed) begin
               n.armed = 1'b0;
               // Manual halt leaves the window one place ahead unless the FIFO is full
               if (r.cnt != `DBT_FIFO_DEPTH) begin
                  n.wrPtr = ptrInc(r.wrPtr);
                  n.rdPtr = ptrInc(r.wrPtr);
               end
            end
         end
      end
      // Trace run, gated by the armed state before this edge
      if (r.armed) begin
         if (hitA) begin
            n.af = 1'b1;
            n.seenA = 1'b1;
         end
         if (hitB) begin
            n.bf = 1'b1;
         end
         if (trig && r.brkEn && !r.tagSel) begin
            n.forcePend = 1'b1;
         end
         if (tagTrig && r.brkEn && r.tagSel) begin
            n.tagOut = 1'b1;
         end
         if (evMode) begin
            if (trig) begin
               stVal = 1'b1;
               stData = {8'h00, dataB};
            end
         end else if (r.beginSel) begin
            if (!r.tracing) begin
               if (trig) begin
                  n.tracing = 1'b1;
                  n.skip = `DBT_SKIP_CYCLES;
               end
            end else if (r.skip != 2'h0) begin
               n.skip = 2'(r.skip - 2'h1);
            end else if (cofHit) begin
               stVal = 1'b1;
               stData = cofAddr;
            end
         end else begin
            if (cofHit) begin
               stVal = 1'b1;
               stData = cofAddr;
            end
            if (trig) begin
               n.armed = 1'b0;
            end
         end
         // Begin and event runs end once the FIFO is full
         if (stVal && (evMode || r.beginSel) && r.cnt >= 4'h7) begin
            n.armed = 1'b0;
         end
      end else if (lowRead) begin
         stVal = 1'b1;
         stData = r.lastFetch;
      end
      // FIFO window: port shows the slot eight stores back
      if (stVal) begin
         n.cnt = (r.cnt == `DBT_FIFO_DEPTH) ? r.cnt : 4'(r.cnt + 4'h1);
         n.wrPtr = ptrInc(r.wrPtr);
         n.rdPtr = ptrInc(r.wrPtr);
      end else if (lowRead) begin
         n.rdPtr = ptrInc(r.rdPtr);
      end
      if (cpu.valid && cpu.opFetch) begin
         n.lastFetch = cpu.addr;
      end
      // Controller breakpoint
      if (ctrlHit && r.force_tag_select) begin
         n.forcePend = 1'b1;
      end else if (cpu.instrBoundary && r.forcePend && !(trig && r.armed && r.brkEn)) begin
         n.forcePend = 1'b0;
      end
      if (ctrlHit && !r.force_tag_select && cpu.opFetch) begin
         n.tagOut = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   dbt_fifo_mem #(
      .W(16),
      .D(8),
      .AW(3)
   ) u_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .wrEn(stVal),
      .wrAddr(r.wrPtr),
      .wrData(stData),
      .rdAddr(r.rdPtr),
      .rdData(fifoWord)
   );

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = r.hrdata;
   assign bgndForce = r.forcePend;
   assign opTag = r.tagOut;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence armWrite;
      r.wrPend && r.wrAddr == `DBT_OFF_TCTRL && hwdata[`DBT_TC_ARM] && !r.armed;
   endsequence
   sequence profRead;
      !r.armed && lowRead;
   endsequence

   bkpt_off_a: assert property (!r.ctrl_breakpoint_enable && !r.armed && !r.forcePend |=> !bgndForce)
      else $error("breakpoint raised while disabled");
   force_req_a: assert property (r.ctrl_breakpoint_enable && r.force_tag_select && cpu.valid && cpu.addr == r.bkptMatch
      |=> bgndForce)
      else $error("forced breakpoint not requested");
   tag_req_a: assert property (r.ctrl_breakpoint_enable && !r.force_tag_select && cpu.valid && cpu.opFetch
      && cpu.addr == r.bkptMatch |=> opTag)
      else $error("tag not raised on fetch");
   cnt_sat_a: assert property (r.cnt <= `DBT_FIFO_DEPTH)
      else $error("count beyond eight");
   arm_start_a: assert property (armWrite |=> r.armed && r.cnt == 4'h0 && !r.af && !r.bf)
      else $error("arm did not start run");
   bdc_supp_a: assert property (cpu.bdcAccess && !r.trgSel && r.armed |=> $stable(r.af)
      || !r.armed)
      else $error("match during controller access");
   prof_push_a: assert property (profRead ##0 (r.cnt != `DBT_FIFO_DEPTH) |=> $changed(r.cnt)
      ##1 $stable(r.wrPtr) [*1])
      else $error("profiling read did not push");
   full_stop_a: assert property (r.armed && r.beginSel && !evMode && r.cnt == 4'h7 && stVal
      |=> !r.armed && r.cnt == `DBT_FIFO_DEPTH)
      else $error("begin run did not stop when full");
   br_skip_a: assert property (r.armed && !r.wrPend && !evMode && cof.valid
      && (cof.kind == COF_ALWAYS || cof.kind == COF_NEVER) |=> $stable(r.wrPtr))
      else $error("unconditional branch stored");
   skip_two_a: assert property (r.armed && r.beginSel && !evMode && !r.tracing && trig
      |=> !stVal ##1 !stVal)
      else $error("flow change stored too early");
endmodule // dbt_top

// ---- verif/dbt_cpu_model.sv ----
// CPU side model for the debug/trace unit: bus cycles and flow-change pulses.
// Assumes the bench calls step/idle from one process, right after rising edges.
`timescale 1ns/1ps
module dbt_cpu_model
   import dbt_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // CPU buses and flow events
   output dbt_cpu_t cpu,
   output dbt_cof_t cof
);
   initial begin
      cpu = '0;
      cof = '0;
   end

   // One bus cycle, sampled by the unit at the next edge
   task automatic step(input dbt_cpu_t c, input dbt_cof_t f);
      @(posedge ref_clk);
      cpu <= c;
      cof <= f;
   endtask

   // Strobes drop; released lines except the flow kind show the inverse so stale values never match
   task automatic idle();
      @(posedge ref_clk);
      cpu <= '{valid: 1'b0, addr: ~cpu.addr, rw: ~cpu.rw, rdData: ~cpu.rdData,
         wrData: ~cpu.wrData, bdcAccess: 1'b0, opFetch: 1'b0, opExec: 1'b0,
         execAddr: ~cpu.execAddr, instrBoundary: 1'b0};
      cof <= '{valid: 1'b0, kind: cof.kind, src: ~cof.src, dst: ~cof.dst};
   endtask
endmodule // dbt_cpu_model

// ---- verif/dbt_top_bench.sv ----
// Self-checking bench of the debug/trace unit over AHB-Lite and the CPU model.
// Assumes zero-wait slave and the register map of dbt_cfg.svh.
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_top_bench
   import dbt_pkg::*;
;
   localparam logic [7:0] CS = `DBT_OFF_BDC_CS;
   localparam logic [7:0] BK = `DBT_OFF_BDC_BKPT;
   localparam logic [7:0] CA = `DBT_OFF_CMPA;
   localparam logic [7:0] CB = `DBT_OFF_CMPB;
   localparam logic [7:0] TC = `DBT_OFF_TCTRL;
   localparam logic [7:0] TS = `DBT_OFF_TSTAT;
   localparam logic [7:0] FH = `DBT_OFF_FIFOH;
   localparam logic [7:0] FL = `DBT_OFF_FIFOL;
   localparam dbt_cof_t NOCOF = '0;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic dbgPortAccess = 1'b0;
   logic hready, hreadyout, hresp, bgndForce, opTag;
   logic [31:0] hrdata, q, hi, lo;
   dbt_cpu_t cpu;
   dbt_cof_t cof;
   dbt_cof_kind_t k;
   logic [15:0] expQ[$];
   int errors = 0;
   int numChecks = 0;
   int cycles = 0;
   int i;

   assign hready = hreadyout;
   always #5 ref_clk = ~ref_clk;

   dbt_top i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .dbgPortAccess(dbgPortAccess), .cpu(cpu), .cof(cof),
      .bgndForce(bgndForce), .opTag(opTag));
   dbt_cpu_model i_cpu (.ref_clk(ref_clk), .cpu(cpu), .cof(cof));

   task automatic summarize();
      if (errors == 0 && numChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic dp, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      dbgPortAccess <= dp;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? wd : ~hwdata;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] t;
      xfer(1'b1, 1'b1, a, d, t);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] t;
      xfer(1'b0, 1'b1, a, 32'h0, t);
      chk(t & m, e);
   endtask

   // f holds {boundary, exec, bdc, fetch}
   function automatic dbt_cpu_t mk(input logic [15:0] a, input logic rw,
      input logic [7:0] rdd, input logic [7:0] wrd, input logic [3:0] f);
      return '{valid: 1'b1, addr: a, rw: rw, rdData: rdd, wrData: wrd, bdcAccess: f[1],
         opFetch: f[0], opExec: f[2], execAddr: a, instrBoundary: f[3]};
   endfunction

   function automatic dbt_cof_t cf(input dbt_cof_kind_t kd, input logic [15:0] s,
      input logic [15:0] d);
      return '{valid: 1'b1, kind: kd, src: s, dst: d};
   endfunction

   // End-trace run: first cycle must not trigger, second must disarm
   task automatic endRun(input logic [15:0] a, input logic [15:0] b, input dbt_mode_t md,
      input logic [7:0] fl, input dbt_cpu_t no, input dbt_cpu_t yes);
      wr(CA, {16'h0, a});
      wr(CB, {16'h0, b});
      wr(TC, {16'h0, md, 4'h0, fl | 8'h01});
      rdChk(TS, 32'h7, 32'h1);
      i_cpu.step(no, NOCOF);
      i_cpu.idle();
      rdChk(TS, 32'h1, 32'h1);
      i_cpu.step(yes, NOCOF);
      i_cpu.idle();
      rdChk(TS, 32'h1, 32'h0);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rdChk(CS, 32'hffffffff, 32'h0);
      xfer(1'b1, 1'b0, CS, 32'h3, q);
      chk({31'h0, hresp}, 32'h0);
      rdChk(CS, 32'hffffffff, 32'h0);
      rdChk(8'h40, 32'hffffffff, 32'h0);
      wr(CS, 32'h3);
      wr(BK, 32'h1234);
      xfer(1'b0, 1'b0, BK, 32'h0, q);
      chk(q, 32'h0);
      rdChk(BK, 32'hffff, 32'h1234);
      i_cpu.step(mk(16'h1234, 1'b0, 8'h0, 8'h0, 4'h0), NOCOF);
      i_cpu.idle();
      #1 chk({31'h0, bgndForce}, 32'h1);
      i_cpu.step(mk(16'h1300, 1'b1, 8'h0, 8'h0, 4'h8), NOCOF);
      #1 chk({31'h0, bgndForce}, 32'h1);
      i_cpu.idle();
      #1 chk({31'h0, bgndForce}, 32'h0);
      wr(CS, 32'h1);
      i_cpu.step(mk(16'h1234, 1'b1, 8'h0, 8'h0, 4'h1), NOCOF);
      i_cpu.idle();
      #1 chk({30'h0, bgndForce, opTag}, 32'h1);
      i_cpu.idle();
      #1 chk({31'h0, opTag}, 32'h0);
      i_cpu.step(mk(16'h1234, 1'b1, 8'h0, 8'h0, 4'h0), NOCOF);
      i_cpu.idle();
      #1 chk({30'h0, bgndForce, opTag}, 32'h0);
      wr(CS, 32'h2);
      i_cpu.step(mk(16'h1234, 1'b1, 8'h0, 8'h0, 4'h0), NOCOF);
      i_cpu.idle();
      #1 chk({31'h0, bgndForce}, 32'h0);
      endRun(16'h4000, 16'h005a, MODE_A_AND_B_DATA, 8'h20, mk(16'h4000, 1'b0, 8'h5a, 8'ha5,
         4'h0), mk(16'h4000, 1'b0, 8'ha5, 8'h5a, 4'h0));
      endRun(16'h1000, 16'h1fff, MODE_INSIDE, 8'h00, mk(16'h0fff, 1'b1, 8'h0, 8'h0, 4'h0),
         mk(16'h1000, 1'b1, 8'h0, 8'h0, 4'h0));
      endRun(16'h1000, 16'h1fff, MODE_OUTSIDE, 8'h00, mk(16'h1fff, 1'b1, 8'h0, 8'h0, 4'h0),
         mk(16'h2000, 1'b1, 8'h0, 8'h0, 4'h0));
      endRun(16'h5000, 16'h0, MODE_A_ONLY, 8'h08, mk(16'h5000, 1'b1, 8'h0, 8'h0, 4'h1),
         mk(16'h5000, 1'b1, 8'h0, 8'h0, 4'h4));
      endRun(16'h7000, 16'h0, MODE_A_ONLY, 8'h60, mk(16'h7000, 1'b0, 8'h0, 8'h0, 4'h0),
         mk(16'h7000, 1'b1, 8'h0, 8'h0, 4'h0));
      endRun(16'h0100, 16'h0200, MODE_A_OR_B, 8'h00, mk(16'h0300, 1'b1, 8'h0, 8'h0, 4'h0),
         mk(16'h0200, 1'b1, 8'h0, 8'h0, 4'h0));
      endRun(16'h0400, 16'h0500, MODE_A_THEN_B, 8'h00, mk(16'h0400, 1'b1, 8'h0, 8'h0, 4'h0),
         mk(16'h0500, 1'b1, 8'h0, 8'h0, 4'h0));
      endRun(16'h4000, 16'h005a, MODE_A_AND_NOT_B_DATA, 8'h00, mk(16'h4000, 1'b1, 8'h5a, 8'h0,
         4'h0), mk(16'h4000, 1'b1, 8'h5b, 8'h0, 4'h0));
      endRun(16'h6000, 16'h0, MODE_A_ONLY, 8'h02, mk(16'h6000, 1'b1, 8'h0, 8'h0, 4'h2),
         mk(16'h6000, 1'b1, 8'h0, 8'h0, 4'h0));
      #1 chk({31'h0, bgndForce}, 32'h1);
      i_cpu.step(mk(16'h6100, 1'b1, 8'h0, 8'h0, 4'h8), NOCOF);
      i_cpu.idle();
      wr(CA, 32'h2000);
      wr(TC, {16'h0, MODE_A_ONLY, 4'h0, 8'h11});
      i_cpu.step(mk(16'h2000, 1'b1, 8'h0, 8'h0, 4'h0), cf(COF_COND_TAKEN, 16'haaaa, 16'haaab));
      i_cpu.step(mk(16'h2100, 1'b1, 8'h0, 8'h0, 4'h0), cf(COF_INDIRECT, 16'hbbba, 16'hbbbb));
      i_cpu.step(mk(16'h2200, 1'b1, 8'h0, 8'h0, 4'h0), cf(COF_RETURN, 16'hccca, 16'hcccb));
      for (i = 0; i < 16; i++) begin
         k = dbt_cof_kind_t'(3'(i % 7 + 1));
         i_cpu.step(mk(16'h3000 + 16'(i), 1'b1, 8'h0, 8'h0, 4'h0),
            cf(k, 16'h1000 + 16'(i), 16'h8000 + 16'(i)));
         if (expQ.size() < 8 && k == COF_COND_TAKEN) expQ.push_back(16'h1000 + 16'(i));
         if (expQ.size() < 8 && k inside {COF_INDIRECT, COF_INTERRUPT, COF_RETURN})
            expQ.push_back(16'h8000 + 16'(i));
      end
      i_cpu.idle();
      rdChk(TS, 32'hf01, 32'h800);
      for (i = 0; i < 8; i++) begin
         xfer(1'b0, 1'b1, FH, 32'h0, hi);
         xfer(1'b0, 1'b1, FL, 32'h0, lo);
         chk({16'h0, hi[7:0], lo[7:0]}, {16'h0, expQ[i]});
      end
      // End-trace run whose trigger cycle is itself a flow change
      wr(CA, 32'h2a5c);
      wr(TC, {16'h0, MODE_A_ONLY, 4'h0, 8'h01});
      i_cpu.step(mk(16'h2900, 1'b1, 8'h0, 8'h0, 4'h0), cf(COF_INDIRECT, 16'h2901, 16'h9137));
      i_cpu.step(mk(16'h2a5c, 1'b1, 8'h0, 8'h0, 4'h0), cf(COF_COND_TAKEN, 16'h2a5c, 16'h2a70));
      i_cpu.idle();
      rdChk(TS, 32'hf01, 32'h200);
      repeat (6) xfer(1'b0, 1'b1, FL, 32'h0, q);
      rdChk(FL, 32'hff, 32'h37);
      rdChk(FL, 32'hff, 32'h5c);
      wr(CB, 32'h3100);
      wr(TC, {16'h0, MODE_EVENT_B, 4'h0, 8'h01});
      i_cpu.step(mk(16'h3100, 1'b1, 8'h11, 8'hee, 4'h0), NOCOF);
      i_cpu.step(mk(16'h3100, 1'b1, 8'h22, 8'hdd, 4'h0), NOCOF);
      i_cpu.idle();
      rdChk(TS, 32'hf00, 32'h200);
      wr(TC, 32'h0);
      repeat (5) xfer(1'b0, 1'b1, FL, 32'h0, q);
      rdChk(FL, 32'hff, 32'h11);
      rdChk(FL, 32'hff, 32'h22);
      i_cpu.step(mk(16'h7777, 1'b1, 8'h0, 8'h0, 4'h1), NOCOF);
      i_cpu.idle();
      repeat (8) xfer(1'b0, 1'b1, FL, 32'h0, q);
      rdChk(FH, 32'hff, 32'h77);
      rdChk(FL, 32'hff, 32'h77);
      summarize();
   end
endmodule // dbt_top_bench
